// >>> logic/bcr_break_control.sv
// bcr_break_control: break control register with match flags, chaining,
// execution-count gating for channels C and D, and a masked interrupt.
// assumes per-channel comparators outside that pulse CPU/DMA match inputs
// for one cycle per satisfied bus cycle, on the same clock.
//
// Overview of operation
// - power-on reset clears the whole control register; manual reset leaves it alone.
// - a channel A CPU match that breaks sets bit 31.
// - a channel A DMA match that breaks sets bit 30.
// - channel B CPU and DMA matches that break set bits 23 and 22.
// - a channel C CPU match that breaks sets bit 15.
// - match flags stay set until software writes them clear.
// - bit 27 enables program counter trace; off after reset.
// - bit 26 picks break before or after the fetched instruction, channel A.
// - bit 18 picks break before or after the fetched instruction, channel B.
// - bits 20:19 choose independent or chained C-D, B-C-D, A-B-C-D matching.
// - reserved bits read zero; software writes zero there.
// - bits 13 and 5 enable execution-count breaks for C and D.
// - bits 11, 3 enable data compare; bits 10, 2 select fetch break timing.
// - a channel C DMA match that breaks sets bit 14.
// - with count enabled, break only when occurrences reach the programmed count.
// - data compare enable tells comparators to include or ignore the data bus.
//
// The address map and the strobed register port were chosen for this implementation.
`default_nettype none

module bcr_break_control
  import bcr_pkg::*;
#(
  parameter int CW = bcr_pkg::CNT_W
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic MAN_RST_I,
  // register port
  input wire logic [bcr_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [bcr_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [bcr_pkg::DATA_W-1:0] RDATA_O,
  // comparator side, index 0..3 is channel A..D; DATA_CMP_EN_O index 0..1 is channel C..D
  input wire logic [bcr_pkg::NCH-1:0] CPU_MATCH_I,
  input wire logic [bcr_pkg::NCH-1:0] DMA_MATCH_I,
  output logic [bcr_pkg::NCH-1:0] FETCH_AFTER_O,
  output logic [1:0] DATA_CMP_EN_O,
  output logic PC_TRACE_EN_O,
  // break request and interrupt
  output logic BREAK_REQ_O,
  output logic IRQ_O
);
  import bcr_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [CW-1:0] cnt_c;
    logic [CW-1:0] cnt_d;
    logic [1:0] stage;
    logic [NCH-1:0] sts;
    logic [NCH-1:0] msk;
    logic [DATA_W-1:0] rdata;
    logic brk;
  } bcr_state_t;

  bcr_state_t s;
  bcr_state_t next_s;

  // first channel of the chain; NCH means no chain
  function automatic logic [2:0] seq_first(input bcr_seq_t m);
    logic [2:0] f;
    f = 3'h4;
    unique case (m)
      SEQ_INDEP: f = 3'h4;
      SEQ_CD: f = 3'h2;
      SEQ_BCD: f = 3'h1;
      SEQ_ABCD: f = 3'h0;
    endcase
    return f;
  endfunction : seq_first

  // shared execution-count gate: returns 1 when the occurrence may break
  function automatic logic cnt_pass(input logic en, input logic [CW-1:0] c);
    return !en || (c <= CW'(1));
  endfunction : cnt_pass

  bcr_seq_t mode;
  logic [2:0] first;
  logic [1:0] eff;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] req;
  logic wr_ctrl;
  logic [DATA_W-1:0] setv;

  assign mode = bcr_seq_t'(s.ctrl[SEQ_HI_BIT:SEQ_LO_BIT]);
  assign first = seq_first(mode);
  assign hit = CPU_MATCH_I | DMA_MATCH_I;
  assign wr_ctrl = WR_I && (ADDR_I == OFS_CTRL);
  // a stale stage from an earlier mode restarts at the chain head
  assign eff = ({1'b0, s.stage} < first) ? first[1:0] : s.stage;

  always_comb begin
    next_s = s;
    next_s.brk = 1'b0;
    req = '0;
    setv = '0;
    // independent channels break on their own hit
    for (int i = 0; i < NCH; i++) begin
      if (3'(i) < first) begin
        req[i] = hit[i];
      end
    end
    // chained channels advance a stage; only the last one breaks
    if (first < 3'h4 && hit[eff]) begin
      if (eff == 2'h3) begin
        req[3] = 1'b1;
        next_s.stage = first[1:0];
      end else begin
        next_s.stage = eff + 2'h1;
      end
    end
    // execution count: each occurrence counts down, break once it reaches one
    if (req[2] && s.ctrl[EXC_C_BIT]) begin
      if (s.cnt_c != '0) begin
        next_s.cnt_c = s.cnt_c - CW'(1);
      end
      req[2] = cnt_pass(1'b1, s.cnt_c);
    end
    if (req[3] && s.ctrl[EXC_D_BIT]) begin
      if (s.cnt_d != '0) begin
        next_s.cnt_d = s.cnt_d - CW'(1);
      end
      req[3] = cnt_pass(1'b1, s.cnt_d);
    end
    // flags name the cycle type behind each break
    for (int i = 0; i < NCH; i++) begin
      setv[CPU_FLAG_A_BIT - CH_STRIDE * i] = req[i] & CPU_MATCH_I[i];
      setv[CPU_FLAG_A_BIT - 1 - CH_STRIDE * i] = req[i] & DMA_MATCH_I[i];
    end
    // write: control bits load, flags only clear on zero; set wins
    if (wr_ctrl) begin
      next_s.ctrl = (WDATA_I & CTRL_WMASK) | (s.ctrl & WDATA_I & FLAG_MASK);
    end
    next_s.ctrl = next_s.ctrl | setv;
    if (WR_I && ADDR_I == OFS_CNT_C) begin
      next_s.cnt_c = WDATA_I[CW-1:0];
    end
    if (WR_I && ADDR_I == OFS_CNT_D) begin
      next_s.cnt_d = WDATA_I[CW-1:0];
    end
    if (WR_I && ADDR_I == OFS_MSK) begin
      next_s.msk = WDATA_I[NCH-1:0];
    end
    // status is write-one-to-clear; a new break in the same cycle survives
    if (WR_I && ADDR_I == OFS_STS) begin
      next_s.sts = s.sts & ~WDATA_I[NCH-1:0];
    end
    next_s.sts = next_s.sts | req;
    next_s.brk = |req;
    // manual reset only restarts the chain, register contents are kept
    if (MAN_RST_I) begin
      next_s.stage = 2'h0;
    end
    // read data stand for the one cycle after the strobe
    next_s.rdata = '0;
    if (RD_I) begin
      unique case (ADDR_I)
        OFS_CTRL: next_s.rdata = s.ctrl;
        OFS_CNT_C: next_s.rdata = DATA_W'(s.cnt_c);
        OFS_CNT_D: next_s.rdata = DATA_W'(s.cnt_d);
        OFS_STS: next_s.rdata = DATA_W'(s.sts);
        OFS_MSK: next_s.rdata = DATA_W'(s.msk);
        default: next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.cnt_c <= CNT_RESET;
      s.cnt_d <= CNT_RESET;
      s.sts <= STS_RESET;
      s.msk <= STS_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign RDATA_O = s.rdata;
  assign BREAK_REQ_O = s.brk;
  assign IRQ_O = |(s.sts & s.msk);
  assign PC_TRACE_EN_O = s.ctrl[TRACE_BIT];
  assign FETCH_AFTER_O = {s.ctrl[FETCH_D_BIT], s.ctrl[FETCH_C_BIT],
                          s.ctrl[FETCH_B_BIT], s.ctrl[FETCH_A_BIT]};
  // comparators fold the data bus in only when these are set
  assign DATA_CMP_EN_O = {s.ctrl[DCMP_D_BIT], s.ctrl[DCMP_C_BIT]};

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);

  a_reset_clears: assert property ($past(RST_I) |-> s.ctrl == CTRL_RESET)
    else $error("control register not zero after reset");

  a_cpu_flag_a: assert property (CPU_MATCH_I[0] && mode == SEQ_INDEP |=> s.ctrl[31])
    else $error("channel A cpu flag not set");

  a_dma_flag_a: assert property (DMA_MATCH_I[0] && mode != SEQ_ABCD |=> s.ctrl[30])
    else $error("channel A dma flag not set");

  // each match line must set its own flag; one bus cycle carries only one of them
  a_flags_chan_b: assert property ((mode == SEQ_INDEP || mode == SEQ_CD) && hit[1]
      |=> (s.ctrl[23] || !$past(CPU_MATCH_I[1])) && (s.ctrl[22] || !$past(DMA_MATCH_I[1])))
    else $error("channel B flags not set");

  // channel C is the chain head in the C-D mode, so only independent mode sets its flags
  a_flags_chan_c: assert property (mode == SEQ_INDEP && !s.ctrl[EXC_C_BIT] && hit[2]
      |=> (s.ctrl[15] || !$past(CPU_MATCH_I[2])) && (s.ctrl[14] || !$past(DMA_MATCH_I[2])))
    else $error("channel C flags not set");

  a_flags_sticky: assert property (!wr_ctrl |=> ($past(s.ctrl) & FLAG_MASK & ~s.ctrl) == '0)
    else $error("match flag cleared without a write");

  a_trace_follows: assert property (wr_ctrl |=> PC_TRACE_EN_O == $past(WDATA_I[TRACE_BIT]))
    else $error("trace enable does not follow write");

  a_fetch_select: assert property (wr_ctrl |=> FETCH_AFTER_O[0] == $past(WDATA_I[FETCH_A_BIT])
      && FETCH_AFTER_O[1] == $past(WDATA_I[FETCH_B_BIT]))
    else $error("fetch break select wrong");

  a_reserved_zero: assert property (RD_I && ADDR_I == OFS_CTRL
      |=> (RDATA_O & ~(CTRL_WMASK | FLAG_MASK)) == '0)
    else $error("reserved bits read nonzero");

  a_chain_head_quiet: assert property (mode == SEQ_ABCD && hit == 4'h1 |=> !BREAK_REQ_O)
    else $error("chain head raised a break");

  a_count_holds: assert property (mode == SEQ_INDEP && s.ctrl[EXC_C_BIT] && s.cnt_c > CW'(1)
      && hit == 4'h4 && !WR_I |=> !BREAK_REQ_O && s.cnt_c == $past(s.cnt_c) - CW'(1))
    else $error("execution count did not gate break");

  a_data_enable: assert property (wr_ctrl |=> DATA_CMP_EN_O == {$past(WDATA_I[DCMP_D_BIT]),
      $past(WDATA_I[DCMP_C_BIT])})
    else $error("data compare enable wrong");

  // outputs and side registers after power-on reset
  a_outputs_reset: assert property ($past(RST_I) |-> !PC_TRACE_EN_O
      && FETCH_AFTER_O == '0 && DATA_CMP_EN_O == '0 && !IRQ_O)
    else $error("outputs not idle after reset");

  a_counts_reset: assert property ($past(RST_I) |-> s.cnt_c == '0
      && s.cnt_d == '0 && s.sts == '0 && s.msk == '0)
    else $error("side registers not zero after reset");

  // manual reset must not disturb software-visible contents
  a_man_reset_keeps: assert property (MAN_RST_I && !WR_I && hit == '0
      |=> s.ctrl == $past(s.ctrl) && s.stage == 2'h0)
    else $error("manual reset changed the register");

  // reserved positions can never hold a one, whatever software writes
  a_reserved_stored: assert property ((s.ctrl & ~(CTRL_WMASK | FLAG_MASK)) == '0)
    else $error("reserved bit stored");

  a_mode_follows: assert property (wr_ctrl
      |=> s.ctrl[SEQ_HI_BIT:SEQ_LO_BIT] == $past(WDATA_I[SEQ_HI_BIT:SEQ_LO_BIT]))
    else $error("sequence select does not follow write");

  a_count_enables: assert property (wr_ctrl
      |=> s.ctrl[EXC_C_BIT] == $past(WDATA_I[EXC_C_BIT])
      && s.ctrl[EXC_D_BIT] == $past(WDATA_I[EXC_D_BIT]))
    else $error("execution count enable does not follow write");

  a_fetch_cd: assert property (wr_ctrl
      |=> FETCH_AFTER_O[2] == $past(WDATA_I[FETCH_C_BIT])
      && FETCH_AFTER_O[3] == $past(WDATA_I[FETCH_D_BIT]))
    else $error("fetch break select C or D wrong");

  // flag write semantics: zero clears unless hardware sets in the same cycle
  a_flag_write_clear: assert property (wr_ctrl && !WDATA_I[31] && !CPU_MATCH_I[0]
      |=> !s.ctrl[31])
    else $error("flag not cleared by a zero write");

  a_flag_write_keep: assert property (wr_ctrl && WDATA_I[31] && s.ctrl[31]
      |=> s.ctrl[31])
    else $error("flag lost on a one write");

  a_flag_set_wins: assert property (wr_ctrl && !WDATA_I[31] && CPU_MATCH_I[0]
      && mode == SEQ_INDEP |=> s.ctrl[31])
    else $error("clearing write beat a hardware set");

  // channel D breaks alone in independent mode, and only as the chain end otherwise
  a_cpu_flag_d: assert property (!s.ctrl[EXC_D_BIT] && CPU_MATCH_I[3]
      && (first == 3'h4 || eff == 2'h3) |=> s.ctrl[7])
    else $error("channel D cpu flag not set");

  a_dma_flag_d: assert property (!s.ctrl[EXC_D_BIT] && DMA_MATCH_I[3]
      && (first == 3'h4 || eff == 2'h3) |=> s.ctrl[6])
    else $error("channel D dma flag not set");

  // no hit, no break: the request is never invented
  a_break_needs_hit: assert property (hit == '0 |=> !BREAK_REQ_O)
    else $error("break without a match");

  a_break_status: assert property (BREAK_REQ_O |-> s.sts != '0)
    else $error("break left no status bit");

  a_status_clear: assert property (WR_I && ADDR_I == OFS_STS && WDATA_I[0]
      && !hit[0] |=> !s.sts[0])
    else $error("status bit not cleared");

  // until the chain has reached D, the full chain stays silent
  a_chain_waits: assert property (mode == SEQ_ABCD && s.stage != 2'h3 |=> !BREAK_REQ_O)
    else $error("chain broke before its last stage");

  a_chain_advance: assert property (mode == SEQ_ABCD && hit == 4'h1
      && s.stage == 2'h0 && !MAN_RST_I |=> s.stage == 2'h1)
    else $error("chain did not advance");

  a_chain_cd_quiet: assert property (mode == SEQ_CD && hit == 4'h4 && !wr_ctrl
      |=> !BREAK_REQ_O && s.ctrl[15:14] == $past(s.ctrl[15:14]))
    else $error("chain head of C-D raised a break or flag");

  // execution count: the last occurrence breaks, plain mode breaks every time
  a_count_final: assert property (mode == SEQ_INDEP && s.ctrl[EXC_C_BIT]
      && s.cnt_c == CW'(1) && hit == 4'h4 && !WR_I |=> BREAK_REQ_O && s.cnt_c == '0)
    else $error("execution count C did not break at one");

  a_count_d_final: assert property (mode == SEQ_INDEP && s.ctrl[EXC_D_BIT]
      && s.cnt_d == CW'(1) && hit == 4'h8 && !WR_I |=> BREAK_REQ_O && s.cnt_d == '0)
    else $error("execution count D did not break at one");

  a_count_d_holds: assert property (mode == SEQ_INDEP && s.ctrl[EXC_D_BIT]
      && s.cnt_d > CW'(1) && hit == 4'h8 && !WR_I
      |=> !BREAK_REQ_O && s.cnt_d == $past(s.cnt_d) - CW'(1))
    else $error("execution count D did not gate break");

  a_count_off: assert property (mode == SEQ_INDEP && !s.ctrl[EXC_C_BIT] && hit[2]
      |=> BREAK_REQ_O)
    else $error("ungated channel C did not break");

endmodule : bcr_break_control

`default_nettype wire

// >>> logic/bcr_pkg.sv
// bcr_pkg: constants and types for the break control register block.
// assumes a single system clock and a plain strobe register port.
`default_nettype none

package bcr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NCH = 4;
  localparam int CNT_W = 12;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CNT_C = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CNT_D = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MSK = 8'h10;

  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  // plain read/write control bits
  localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h0C1C_2C2C;
  // match flags, cleared by writing zero
  localparam logic [DATA_W-1:0] FLAG_MASK = 32'hC0C0_C0C0;
  localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
  localparam logic [NCH-1:0] STS_RESET = 4'h0;

  // field positions
  localparam int TRACE_BIT = 27;
  localparam int FETCH_A_BIT = 26;
  localparam int FETCH_B_BIT = 18;
  localparam int FETCH_C_BIT = 10;
  localparam int FETCH_D_BIT = 2;
  localparam int SEQ_HI_BIT = 20;
  localparam int SEQ_LO_BIT = 19;
  localparam int EXC_C_BIT = 13;
  localparam int EXC_D_BIT = 5;
  localparam int DCMP_C_BIT = 11;
  localparam int DCMP_D_BIT = 3;
  localparam int CPU_FLAG_A_BIT = 31;
  localparam int CH_STRIDE = 8;

  typedef enum logic [1:0] {
    SEQ_INDEP,
    SEQ_CD,
    SEQ_BCD,
    SEQ_ABCD
  } bcr_seq_t;

endpackage : bcr_pkg

`default_nettype wire

// >>> sim/bcr_cmp_model.sv
// bcr_cmp_model: stand-in for the per-channel break comparators.
// assumes one clock; a request pulses one match line 1..4 cycles after go_i is taken.
`default_nettype none

module bcr_cmp_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request from the bench
  input wire logic go_i,
  input wire logic dma_i,
  input wire logic [1:0] ch_i,
  input wire logic [1:0] dly_i,
  // match pulses, index 0..3 is channel A..D
  output logic [3:0] cpu_o,
  output logic [3:0] dma_o,
  output logic busy_o
);
  logic [1:0] ch;
  logic [1:0] cnt;
  logic dma;

  // one bus cycle gives exactly one pulse, never a level
  always_ff @(posedge clk_i) begin
    cpu_o <= 4'h0;
    dma_o <= 4'h0;
    if (rst_i) begin
      busy_o <= 1'b0;
    end else if (go_i) begin
      busy_o <= 1'b1;
      cnt <= dly_i;
      ch <= ch_i;
      dma <= dma_i;
    end else if (busy_o) begin
      cnt <= cnt - 2'h1;
      if (cnt == 2'h0) begin
        busy_o <= 1'b0;
        if (dma) dma_o[ch] <= 1'b1;
        else cpu_o[ch] <= 1'b1;
      end
    end
  end
endmodule : bcr_cmp_model

`default_nettype wire

// >>> sim/test_break_control_register.sv
// test_break_control_register: register, flag, chain and count tests.
// assumes bcr_cmp_model drives the match inputs.
`default_nettype none

module test_break_control_register;
  import bcr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic CLOCK_I = 1'b0;
  logic RST_I = 1'b1;
  logic MAN_RST_I = 1'b0;
  logic [ADDR_W-1:0] ADDR_I = 8'h00;
  logic [DATA_W-1:0] WDATA_I = 32'h0;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic go = 1'b0;
  logic dma = 1'b0;
  logic [1:0] ch = 2'h0;
  logic [1:0] dly = 2'h0;
  logic [DATA_W-1:0] RDATA_O;
  logic [3:0] CPU_MATCH_I, DMA_MATCH_I, FETCH_AFTER_O;
  logic [1:0] DATA_CMP_EN_O;
  logic PC_TRACE_EN_O, BREAK_REQ_O, IRQ_O, busy;
  int miscompares = 0;
  int checked = 0;
  int nbrk = 0;
  int ebrk = 0;

  always #2.5 CLOCK_I = ~CLOCK_I;
  always @(posedge CLOCK_I) if (BREAK_REQ_O === 1'b1) nbrk <= nbrk + 1;

  bcr_break_control u_bcr_break_control (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
    .MAN_RST_I(MAN_RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .RDATA_O(RDATA_O), .CPU_MATCH_I(CPU_MATCH_I), .DMA_MATCH_I(DMA_MATCH_I),
    .FETCH_AFTER_O(FETCH_AFTER_O), .DATA_CMP_EN_O(DATA_CMP_EN_O),
    .PC_TRACE_EN_O(PC_TRACE_EN_O), .BREAK_REQ_O(BREAK_REQ_O), .IRQ_O(IRQ_O));
  bcr_cmp_model u_bcr_cmp_model (.clk_i(CLOCK_I), .rst_i(RST_I), .go_i(go), .dma_i(dma),
    .ch_i(ch), .dly_i(dly), .cpu_o(CPU_MATCH_I), .dma_o(DMA_MATCH_I), .busy_o(busy));

  task automatic summarize;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK_I);
    WR_I <= 1'b1;
    ADDR_I <= a;
    WDATA_I <= d;
    @(posedge CLOCK_I);
    WR_I <= 1'b0;
  endtask : wr

  // read data live only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLOCK_I);
    RD_I <= 1'b1;
    ADDR_I <= a;
    @(posedge CLOCK_I);
    RD_I <= 1'b0;
    #1 chk(RDATA_O, e);
  endtask : rd

  task automatic hit(input int c, input int d);
    @(posedge CLOCK_I);
    go <= 1'b1;
    ch <= 2'(c);
    dma <= d[0];
    dly <= 2'($urandom % 4);
    @(posedge CLOCK_I);
    go <= 1'b0;
    // let the model's busy flag settle before polling it
    #1;
    for (int i = 0; i < 8 && busy !== 1'b0; i++) begin
      @(posedge CLOCK_I);
      #1;
    end
    if (busy !== 1'b0) begin
      miscompares++;
      summarize();
    end
    repeat (2) @(posedge CLOCK_I);
    #1;
  endtask : hit

  initial begin : main
    logic [31:0] d, e;
    d = $urandom(47);
    repeat (2) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_STS, 32'h0);
    chk({PC_TRACE_EN_O, DATA_CMP_EN_O, FETCH_AFTER_O, IRQ_O}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      e = d & CTRL_WMASK;
      wr(OFS_CTRL, d);
      rd(OFS_CTRL, e);
      chk({PC_TRACE_EN_O, DATA_CMP_EN_O, FETCH_AFTER_O},
          {e[27], e[3], e[11], e[2], e[10], e[18], e[26]});
    end
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    wr(OFS_CTRL, 32'h0);
    $display("test control bits done");
    for (int c = 0; c < 8; c++) begin
      d = $urandom & 32'hF;
      e = 32'h8000_0000 >> (c / 2 * 8 + c % 2);
      wr(OFS_MSK, d);
      hit(c / 2, c % 2);
      ebrk++;
      rd(OFS_CTRL, e);
      rd(OFS_STS, 32'h1 << (c / 2));
      chk(IRQ_O, d[c/2]);
      wr(OFS_CTRL, e);
      rd(OFS_CTRL, e);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_STS, 32'hF);
      rd(OFS_CTRL, 32'h0);
      chk(IRQ_O, 1'b0);
    end
    chk(nbrk, ebrk);
    $display("test match flags done");
    for (int q = 0; q < 4; q++) begin
      wr(OFS_CTRL, q << 19);
      @(posedge CLOCK_I);
      MAN_RST_I <= 1'b1;
      @(posedge CLOCK_I);
      MAN_RST_I <= 1'b0;
      hit(3, 0);
      for (int c = 0; c < 4; c++) hit(c, 0);
      ebrk += 4 - q + int'(q == 0);
      e = (q << 19) | 32'h80 | (32'(q < 3) << 31) | (32'(q < 2) << 23) | (32'(q == 0) << 15);
      rd(OFS_CTRL, e);
      chk(nbrk, ebrk);
    end
    $display("test sequence modes done");
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL, k ? 32'h20 : 32'h2000);
      wr(k ? OFS_CNT_D : OFS_CNT_C, 32'h3);
      for (int j = 0; j < 3; j++) begin
        hit(2 + k, $urandom % 2);
        ebrk += int'(j == 2);
        chk(nbrk, ebrk);
      end
      rd(k ? OFS_CNT_D : OFS_CNT_C, 32'h0);
    end
    $display("test execution count done");
    summarize();
  end

  initial begin : watchdog
    #200000;
    miscompares++;
    summarize();
  end
endmodule : test_break_control_register

`default_nettype wire
